/* File: hw/acs_pkg.sv */
// acs_pkg: register offsets, field positions, reset values and timing counts
// for the converter sequencer; assumes a 100 MHz core clock.
package acs_pkg;
    // ******************************
    // register offsets
    // ******************************
    localparam logic [2:0] ACS_CTL0_OFS   = 3'h0;
    localparam logic [2:0] ACS_CTL1_OFS   = 3'h1;
    localparam logic [2:0] ACS_DATAH_OFS  = 3'h2;
    localparam logic [2:0] ACS_DATAL_OFS  = 3'h3;
    localparam logic [2:0] ACS_STATUS_OFS = 3'h4;
    // ******************************
    // field positions
    // ******************************
    localparam int ACS_CTL0_ANALOG_INPUT_SELECT_LSB = 0;  // analog_input_select [3:0]
    localparam int ACS_CTL0_REFL_BIT  = 4;  // ref_level_lo_bit
    localparam int ACS_CTL0_REFO_BIT  = 5;  // ref_pin_output
    localparam int ACS_CTL0_CONTINUOUS_SELECT_BIT  = 6;  // continuous_select
    localparam int ACS_CTL0_CEN_BIT   = 7;  // conv_enable
    localparam int ACS_CTL1_MODE_LSB  = 0;  // input_stage_mode [2:0]
    localparam int ACS_CTL1_REFH_BIT  = 7;  // ref_level_hi_bit
    localparam int ACS_DATAL_OVF_BIT  = 0;  // hw_overflow_flag
    // ******************************
    // reset values and codes
    // ******************************
    localparam logic [7:0]  ACS_CTL0_RST     = 8'h00;
    localparam logic [7:0]  ACS_CTL1_RST     = 8'h00;
    localparam logic [12:0] ACS_RESULT_RST   = 13'h0000;
    localparam logic [3:0]  ACS_ANALOG_INPUT_SELECT_OFFSET_CAL_VALUE = 4'h8;
    // ******************************
    // timing
    // ******************************
    localparam int ACS_CLK_MHZ         = 100;
    localparam int ACS_IDLE_CYC        = 160;
    localparam int ACS_PWRUP_CYC       = 40;
    localparam int ACS_SINGLE_CYC      = 5129;
    localparam int ACS_CONTINUOUS_SELECT_CYC        = 256;
    localparam logic [12:0] ACS_SINGLE_LAST = 13'(ACS_SINGLE_CYC - 1);
    localparam logic [12:0] ACS_CONTINUOUS_SELECT_LAST   = 13'(ACS_CONTINUOUS_SELECT_CYC - 1);
    localparam logic [12:0] ACS_PWRUP_LAST  = 13'(ACS_PWRUP_CYC - 1);
    localparam logic [7:0]  ACS_IDLE_LAST   = 8'(ACS_IDLE_CYC - 1);

    typedef enum logic [1:0] {
        ACS_IDLE  = 2'b00,
        ACS_PWRUP = 2'b01,
        ACS_CONV  = 2'b10
    } acs_state_t;
endpackage

/* File: hw/acs_sequencer.sv */
// acs_sequencer: conversion sequencer for a sigma-delta converter.
// assumes modulator outputs arrive from another domain (synchronised here)
// and the interrupt controller samples irq on core_clk.
// Operation
// - store 13-bit result across high/low bytes
// - power down after 160 idle cycles
// - powered-down request waits 40 cycles first
// - single conversion lasts 5129 cycles
// - enable bit reads 1 until the first result
// - single-shot does one conversion then stops
// - continuous bit selects single or continuous
// - enable write starts, config same write
// - continuous clears enable after first result
// - continuous results every 256 cycles after first
// - each new result overwrites old
// - interrupt request after every conversion
// - idle converter raises no new requests
// - overflow flag invalidates other result bits
// - offset-cal code shorts differential inputs
// - reference code split across two registers
// - input field steers the multiplexer
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module acs_sequencer
    import acs_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic [2:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic [12:0] mod_sample,
    input  wire logic        mod_overrange,
    output logic      [3:0]  mux_select,
    output logic      [2:0]  input_stage_mode,
    output logic      [1:0]  ref_level,
    output logic             ref_pin_output,
    output logic             offset_short,
    output logic             analog_powered,
    output logic             conv_active,
    output logic             conv_done_irq
);
    // ******************************
    // registers
    // ******************************
    logic [3:0]  analog_input_select_r;
    logic        refl_r;
    logic        refo_r;
    logic        continuous_select_r;
    logic        cen_r;
    logic [2:0]  mode_r;
    logic        refh_r;
    logic [12:0] result_r;
    logic        ovf_r;
    acs_state_t  state_r;
    logic [12:0] cnt_r;
    logic [7:0]  idle_r;
    logic        powered_r;
    logic        first_r;
    logic        irq_r;
    logic [12:0] samp_s1_r;
    logic [12:0] samp_s2_r;
    logic        ovr_s1_r;
    logic        ovr_s2_r;
    logic [12:0] samp_s3_r;
    logic        ovr_s3_r;
    logic [12:0] samp_hold_r;
    logic        ovr_hold_r;
    logic [7:0]  rdata_r;

    logic wr_ctl0;
    logic wr_ctl1;
    logic start_req;
    logic conv_end;

    // ******************************
    // register write decode
    // ******************************
    // one decoder keeps the strobe qualification identical for both control registers
    function automatic logic acs_wr_hit(input logic       wr_i,
                                        input logic [2:0] addr_i,
                                        input logic [2:0] ofs_i);
        return wr_i && (addr_i == ofs_i);
    endfunction

    assign wr_ctl0   = acs_wr_hit(reg_wr, reg_addr, ACS_CTL0_OFS);
    assign wr_ctl1   = acs_wr_hit(reg_wr, reg_addr, ACS_CTL1_OFS);
    assign start_req = wr_ctl0 && reg_wdata[ACS_CTL0_CEN_BIT];
    assign conv_end  = (state_r == ACS_CONV) &&
                       (cnt_r == (first_r ? ACS_SINGLE_LAST : ACS_CONTINUOUS_SELECT_LAST));

    // ******************************
    // modulator input synchroniser
    // ******************************
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            samp_s1_r <= ACS_RESULT_RST;
            samp_s2_r <= ACS_RESULT_RST;
            ovr_s1_r  <= 1'b0;
            ovr_s2_r  <= 1'b0;
            samp_s3_r <= ACS_RESULT_RST;
            ovr_s3_r  <= 1'b0;
        end else begin
            samp_s1_r <= mod_sample;
            samp_s2_r <= samp_s1_r;
            ovr_s1_r  <= mod_overrange;
            ovr_s2_r  <= ovr_s1_r;
            samp_s3_r <= samp_s2_r;
            ovr_s3_r  <= ovr_s2_r;
        end
    end

    // ******************************
    // sample coherence filter
    // ******************************
    // the sample bits are synchronised one by one, so a word caught while the
    // modulator updates may mix old and new bits; only a word that stays the
    // same for two cycles is trusted, at the price of two cycles of latency
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            samp_hold_r <= ACS_RESULT_RST;
            ovr_hold_r  <= 1'b0;
        end else if ((samp_s2_r == samp_s3_r) && (ovr_s2_r == ovr_s3_r)) begin
            samp_hold_r <= samp_s2_r;
            ovr_hold_r  <= ovr_s2_r;
        end
    end

    // ******************************
    // control register 0
    // ******************************
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            analog_input_select_r <= ACS_CTL0_RST[3:0];
            refl_r  <= ACS_CTL0_RST[ACS_CTL0_REFL_BIT];
            refo_r  <= ACS_CTL0_RST[ACS_CTL0_REFO_BIT];
            continuous_select_r  <= ACS_CTL0_RST[ACS_CTL0_CONTINUOUS_SELECT_BIT];
        end else if (wr_ctl0) begin
            // configuration lands in the same write that starts conversion
            analog_input_select_r <= reg_wdata[ACS_CTL0_ANALOG_INPUT_SELECT_LSB +: 4];
            refl_r  <= reg_wdata[ACS_CTL0_REFL_BIT];
            refo_r  <= reg_wdata[ACS_CTL0_REFO_BIT];
            continuous_select_r  <= reg_wdata[ACS_CTL0_CONTINUOUS_SELECT_BIT];
        end
    end

    // enable bit: set by software, cleared by hardware at completion, so a
    // start written while busy cannot leave it stuck high once idle;
    // a fresh start in the completing cycle wins over the clear
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cen_r <= ACS_CTL0_RST[ACS_CTL0_CEN_BIT];
        end else if (start_req) begin
            cen_r <= 1'b1;
        end else if (conv_end) begin
            cen_r <= 1'b0;
        end
    end

    // ******************************
    // control/status register 1
    // ******************************
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mode_r <= ACS_CTL1_RST[2:0];
            refh_r <= ACS_CTL1_RST[ACS_CTL1_REFH_BIT];
        end else if (wr_ctl1) begin
            mode_r <= reg_wdata[ACS_CTL1_MODE_LSB +: 3];
            refh_r <= reg_wdata[ACS_CTL1_REFH_BIT];
        end
    end

    // ******************************
    // sequencer
    // ******************************
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ACS_IDLE;
            cnt_r   <= 13'h0000;
            first_r <= 1'b0;
        end else begin
            case (state_r)
                ACS_IDLE: begin
                    cnt_r <= 13'h0000;
                    if (start_req) begin
                        first_r <= 1'b1;
                        // powered-down start pays the warm-up first
                        state_r <= powered_r ? ACS_CONV : ACS_PWRUP;
                    end
                end
                ACS_PWRUP: begin
                    if (cnt_r == ACS_PWRUP_LAST) begin
                        cnt_r   <= 13'h0000;
                        state_r <= ACS_CONV;
                    end else begin
                        cnt_r <= cnt_r + 13'h0001;
                    end
                end
                ACS_CONV: begin
                    if (conv_end) begin
                        cnt_r   <= 13'h0000;
                        // a start landing on the completing cycle is taken
                        // as a fresh full conversion rather than lost
                        first_r <= start_req;
                        // continuous keeps going at the short interval
                        if (!continuous_select_r && !start_req) begin
                            state_r <= ACS_IDLE;
                        end
                    end else begin
                        cnt_r <= cnt_r + 13'h0001;
                    end
                end
                default: begin
                    state_r <= ACS_IDLE;
                    cnt_r   <= 13'h0000;
                    first_r <= 1'b0;
                end
            endcase
        end
    end

    // ******************************
    // automatic powerdown
    // ******************************
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            idle_r    <= 8'h00;
            powered_r <= 1'b0;
        end else if (state_r != ACS_IDLE) begin
            idle_r    <= 8'h00;
            powered_r <= 1'b1;
        end else if (start_req) begin
            idle_r <= 8'h00;
        end else if (powered_r) begin
            if (idle_r == ACS_IDLE_LAST) begin
                idle_r    <= 8'h00;
                powered_r <= 1'b0;
            end else begin
                idle_r <= idle_r + 8'h01;
            end
        end
    end

    // ******************************
    // result and interrupt
    // ******************************
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            result_r <= ACS_RESULT_RST;
            ovf_r    <= 1'b0;
        end else if (conv_end) begin
            result_r <= samp_hold_r;
            ovf_r    <= ovr_hold_r;
        end
    end

    // only completions raise a pulse, so an idle converter stays quiet;
    // delivery to the controller is its own latch, never cleared from here
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= conv_end;
        end
    end

    // ******************************
    // register read port
    // ******************************
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                ACS_CTL0_OFS:   rdata_r <= {cen_r, continuous_select_r, refo_r, refl_r, analog_input_select_r};
                ACS_CTL1_OFS:   rdata_r <= {refh_r, 4'h0, mode_r};
                ACS_DATAH_OFS:  rdata_r <= result_r[12:5];
                ACS_DATAL_OFS:  rdata_r <= {result_r[4:0], 2'b00, ovf_r};
                ACS_STATUS_OFS: rdata_r <= {5'h00, powered_r, state_r};
                default:        rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    // ******************************
    // outputs to analog side
    // ******************************
    assign reg_rdata        = rdata_r;
    assign mux_select       = analog_input_select_r;
    assign input_stage_mode = mode_r;
    assign ref_level        = {refh_r, refl_r};
    assign ref_pin_output   = refo_r;
    assign offset_short     = (analog_input_select_r == ACS_ANALOG_INPUT_SELECT_OFFSET_CAL_VALUE);
    assign analog_powered   = powered_r;
    assign conv_active      = (state_r == ACS_CONV);
    assign conv_done_irq    = irq_r;
endmodule
`default_nettype wire

/* File: tb/acs_sequencer_props.sv */
// acs_sequencer_props: port-level assertions for the conversion sequencer.
// assumes it is bound onto acs_sequencer; one clock domain, core_clk.
`timescale 1ns/10ps
`default_nettype none
module acs_sequencer_props
    import acs_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       resetn,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic [3:0] mux_select,
    input wire logic       offset_short,
    input wire logic       analog_powered,
    input wire logic       conv_active,
    input wire logic       conv_done_irq
);
    logic [8:0] idle_r;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // power-up time is counted here too, but stays far below the idle limit
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            idle_r <= 9'h000;
        end else if (conv_active || !analog_powered) begin
            idle_r <= 9'h000;
        end else if (idle_r != 9'h1FF) begin
            idle_r <= idle_r + 9'h001;
        end
    end
    irq_one_cycle_a: assert property (conv_done_irq |=> !conv_done_irq)
        else $error("interrupt request longer than one cycle");
    irq_after_conv_a: assert property (conv_done_irq |->
        $past(conv_active) || $past(conv_active, 2)) else $error("interrupt without conversion");
    conv_powered_a: assert property (conv_active |-> analog_powered)
        else $error("conversion while powered down");
    idle_bound_a: assert property (analog_powered && !conv_active |-> idle_r < 9'h0A0)
        else $error("converter stays powered while idle");
    idle_early_a: assert property ($fell(analog_powered) |-> $past(idle_r) >= 9'h09F)
        else $error("powered down too early");
    offset_short_a: assert property (offset_short == (mux_select == ACS_ANALOG_INPUT_SELECT_OFFSET_CAL_VALUE))
        else $error("input short does not follow selection");
    mux_follow_a: assert property (reg_wr && reg_addr == ACS_CTL0_OFS |=>
        mux_select == $past(reg_wdata[3:0])) else $error("multiplexer not updated");
    start_conv_a: assert property (reg_wr && reg_addr == ACS_CTL0_OFS && reg_wdata[7]
        |-> ##[1:42] conv_active) else $error("start did not begin a conversion");
endmodule
bind acs_sequencer acs_sequencer_props i_props (.core_clk, .resetn, .reg_addr, .reg_wdata,
    .reg_wr, .mux_select, .offset_short, .analog_powered, .conv_active, .conv_done_irq);
`default_nettype wire

/* File: tb/acs_modulator_model.sv */
// acs_modulator_model: behavioural modulator and input multiplexer.
// assumes mux_select and offset_short come straight from the sequencer.
`timescale 1ns/10ps
`default_nettype none
module acs_modulator_model #(
    parameter logic [12:0] OFFSET_CODE = 13'h1F3
) (
    input  wire logic [3:0]  mux_select,
    input  wire logic        offset_short,
    output logic      [12:0] mod_sample,
    output logic             mod_overrange
);
    // source F stands for an input beyond the reference
    assign mod_overrange = (mux_select == 4'hF);
    // shorted inputs leave only the converter offset
    assign mod_sample = offset_short ? OFFSET_CODE : {mux_select, 9'h0A5};
endmodule
`default_nettype wire

/* File: tb/test_adc_conversion_sequencer.sv */
// test_adc_conversion_sequencer: self-checking bench for acs_sequencer.
// assumes the modulator model and the bound checker are compiled alongside.
`timescale 1ns/10ps
`default_nettype none
module test_adc_conversion_sequencer
    import acs_pkg::*;
;
    logic        core_clk, resetn, reg_wr, reg_rd, mod_overrange, ref_pin_output;
    logic        offset_short, analog_powered, conv_active, conv_done_irq;
    logic [2:0]  reg_addr, input_stage_mode;
    logic [7:0]  reg_wdata, reg_rdata, d;
    logic [12:0] mod_sample;
    logic [3:0]  mux_select;
    logic [1:0]  ref_level;
    int          n_errors, num_checks, n, q;
    acs_sequencer i_dut (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .mod_sample, .mod_overrange, .mux_select, .input_stage_mode, .ref_level,
        .ref_pin_output, .offset_short, .analog_powered, .conv_active, .conv_done_irq);
    acs_modulator_model i_mod (.mux_select, .offset_short, .mod_sample, .mod_overrange);
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    function automatic logic [12:0] smp(input logic [3:0] m);
        return {m, 9'h0A5};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // bounded so a lost interrupt cannot hang the run
    task automatic wait_irq;
        n = 0;
        do begin
            @(posedge core_clk);
            #1 n++;
        end while (conv_done_irq !== 1'b1 && n < 6000);
    endtask
    task automatic quiet(input int c);
        q = 0;
        repeat (c) begin
            @(posedge core_clk);
            #1 if (conv_done_irq !== 1'b0) q++;
        end
    endtask
    task automatic res(input logic [12:0] e);
        rd(ACS_DATAH_OFS);
        chk(d, e[12:5]);
        rd(ACS_DATAL_OFS);
        chk(d, {e[4:0], 3'b000});
    endtask
    task automatic t_regs;
        wr(ACS_CTL1_OFS, 8'h85);
        rd(ACS_CTL1_OFS);
        chk(d, 8'h85);
        chk({input_stage_mode, ref_level}, 5'h16);
        rd(3'h7);
        chk(d, 8'h00);
        wr(ACS_DATAH_OFS, 8'hFF);
        res(ACS_RESULT_RST);
        rd(ACS_STATUS_OFS);
        chk(d, 8'h00);
    endtask
    task automatic t_cold;
        wr(ACS_CTL0_OFS, 8'hB3);
        wait_irq;
        chk(16'(n), 16'(ACS_PWRUP_CYC + ACS_SINGLE_CYC));
        chk({ref_level, ref_pin_output}, 3'b111);
        rd(ACS_CTL0_OFS);
        chk(d, 8'h33);
        res(smp(4'h3));
    endtask
    task automatic t_warm;
        wr(ACS_CTL0_OFS, 8'h81);
        rd(ACS_CTL0_OFS);
        chk({d, mux_select, ref_pin_output}, 13'h1022);
        wait_irq;
        chk(16'(n + 2), 16'(ACS_SINGLE_CYC));
        res(smp(4'h1));
        quiet(150);
        chk(16'(q), 16'h0000);
        chk(analog_powered, 1'b1);
        quiet(20);
        chk(analog_powered, 1'b0);
    endtask
    task automatic t_continuous_select;
        wr(ACS_CTL0_OFS, 8'hC5);
        wait_irq;
        chk(16'(n), 16'(ACS_PWRUP_CYC + ACS_SINGLE_CYC));
        rd(ACS_CTL0_OFS);
        chk(d, 8'h45);
        res(smp(4'h5));
        wr(ACS_CTL0_OFS, 8'h4F);
        wait_irq;
        chk(16'(n + 8), 16'(ACS_CONTINUOUS_SELECT_CYC));
        rd(ACS_DATAL_OFS);
        chk(d[0], 1'b1);
        wr(ACS_CTL0_OFS, 8'h08);
        #1 chk(offset_short, 1'b1);
        wait_irq;
        chk(16'(n + 4), 16'(ACS_CONTINUOUS_SELECT_CYC));
        res(13'h1F3);
        quiet(600);
        chk(16'(q), 16'h0000);
    endtask
    task automatic summarize;
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #400000;
        n_errors++;
        summarize;
    end
    initial begin
        {resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = 14'h0000;
        n_errors = 0;
        num_checks = 0;
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        t_regs;
        t_cold;
        t_warm;
        t_continuous_select;
        summarize;
    end
endmodule
`default_nettype wire
